// >>> src/msg_parser_defs.vh
`ifndef MSG_PARSER_DEFS_VH
`define MSG_PARSER_DEFS_VH
// byte codes
`define CH_LF          8'h0A
`define CH_SPACE       8'h20
`define CH_COLON       8'h3A
`define CH_SEMI        8'h3B
`define CH_COMMA       8'h2C
`define CH_STAR        8'h2A
`define CH_QUERY       8'h3F
`define CH_DOT         8'h2E
`define CH_PLUS        8'h2B
`define CH_MINUS       8'h2D
`define CH_E           8'h45
`define CH_K           8'h4B
`define CH_M           8'h4D
`define CH_G           8'h47
// message and response limits
`define MSG_MAX_BYTES  9'h100
`define RSP_MAX_CHARS  9'h100
// status byte bit positions
`define SB_OPER        7
`define SB_MSS         6
`define SB_ESB         5
`define SB_MAV         4
`define SB_MSG         2
// error classes
`define ERR_NONE       2'h0
`define ERR_CMD        2'h1
`define ERR_EXE        2'h2
`define ERR_DEV        2'h3
// tree levels
`define LVL_ROOT       2'h0
`define LVL_MAX        2'h3
`endif

// >>> src/upcase_char.v
`timescale 1ns/10ps
// folds lower-case letters to upper case
module upcase_char
(
    input  wire [7:0] char_in,
    output wire [7:0] char_out
);
    // letters a..z lose bit 5
    assign char_out = (char_in >= 8'h61 && char_in <= 8'h7A) ?
                      (char_in & 8'hDF) : char_in;
endmodule

// >>> src/status_byte_unit.v
`timescale 1ns/10ps
`include "msg_parser_defs.vh"
// status byte assembly and service request
module status_byte_unit
(
    input  wire       ref_clk,
    input  wire       reset,
    input  wire       oper_busy,
    input  wire       event_summary,
    input  wire       msg_avail,
    input  wire       new_status,
    input  wire [7:0] sre_mask,
    input  wire       poll_ack,
    output reg  [7:0] status_reg,
    output reg        srq_reg
);
    wire [7:0] raw;
    wire       mss;
    // bits 3, 1, 0 stay zero
    assign raw = {oper_busy, 1'b0, event_summary, msg_avail, 1'b0,
                  new_status, 2'b00};
    assign mss = |(raw & sre_mask & 8'hBF);
    // register byte; request rises with the summary bit, poll clears it
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            status_reg <= 8'h00;
            srq_reg    <= 1'b0;
        end
        else
        begin
            status_reg <= raw | {1'b0, mss, 6'h00};
            if (mss && !status_reg[`SB_MSS])
                srq_reg <= 1'b1;
            else if (poll_ack || !mss)
                srq_reg <= 1'b0;
        end
    end
endmodule

// >>> src/scpi_message_parser_status.v
`timescale 1ns/10ps
`include "msg_parser_defs.vh"
//Contract
//- semicolons join commands; 256-byte message accepted
//- line-feed or end-or-identify ends message
//- bytes 00h-20h except LF separate parameter
//- parse words, integers, reals, K M G
//- malformed command error; unapplicable execution error
//- reset puts tree position at root
//- terminator returns tree position to root
//- leading colon resolves from root
//- inner colon descends when path valid
//- semicolon keeps current tree position
//- commas separate parameters, path untouched
//- asterisk commands decoded regardless of path; code gives them command error when path_valid low
//- commands executed in string order
//- one response unit per query, semicolons
//- command outside mode gives execution error; code exempts asterisk commands, even with mode_allows low
//- full or short forms, case ignored
//- responses upper case, LF with EOI
//- items comma separated, 256 chars max
//- status byte by query or poll
//- bit 6 service request / summary
//- bits 7, 5, 4 busy, events, output
//- bit 2 new message, 3 1 0 zero
//- enable mask and byte give bit 6
module scpi_message_parser_status
(
    input  wire       ref_clk,
    input  wire       reset,
    input  wire [7:0] rx_data,
    input  wire       rx_valid,
    input  wire       rx_eoi,
    input  wire       oper_busy,
    input  wire       event_summary,
    input  wire       path_valid,
    input  wire       mode_allows,
    input  wire       setting_approx,
    input  wire [7:0] sre_mask,
    input  wire       poll_ack,
    input  wire [7:0] rsp_data,
    input  wire       rsp_valid,
    input  wire       rsp_item_end,
    input  wire       tx_ready,
    output reg  [7:0] tx_data,
    output reg        tx_valid,
    output reg        tx_eoi,
    output reg  [1:0] tree_level,
    output reg        cmd_exec,
    output reg        cmd_common,
    output reg        cmd_query,
    output reg  [7:0] cmd_first,
    output reg  [2:0] param_kind,
    output reg  [1:0] err_class,
    output reg        err_pulse,
    output wire [7:0] service_status_byte,
    output wire       srq
);
    // byte synchronisers, two stages on external pins
    reg [7:0] rxd_s1, rxd_s2;
    reg       rxv_s1, rxv_s2, rxv_s3, eoi_s1, eoi_s2;
    wire      rx_stb = rxv_s2 & ~rxv_s3;
    wire [7:0] ch;
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            rxd_s1 <= 8'h00;
            rxd_s2 <= 8'h00;
            rxv_s1 <= 1'b0;
            rxv_s2 <= 1'b0;
            rxv_s3 <= 1'b0;
            eoi_s1 <= 1'b0;
            eoi_s2 <= 1'b0;
        end
        else
        begin
            rxd_s1 <= rx_data;
            rxd_s2 <= rxd_s1;
            rxv_s1 <= rx_valid;
            rxv_s2 <= rxv_s1;
            rxv_s3 <= rxv_s2;
            eoi_s1 <= rx_eoi;
            eoi_s2 <= eoi_s1;
        end
    end
    // case folding of incoming text
    upcase_char u_fold
    (
        .char_in  (rxd_s2),
        .char_out (ch)
    );
    // parser states
    localparam ST_HEAD  = 3'h0;
    localparam ST_PARAM = 3'h1;
    localparam ST_SKIP  = 3'h2;
    localparam ST_GAP   = 3'h3;
    // parameter kinds
    localparam PK_NONE = 3'h0;
    localparam PK_WORD = 3'h1;
    localparam PK_INT  = 3'h2;
    localparam PK_REAL = 3'h3;
    localparam PK_MULT = 3'h4;
    localparam PK_BAD  = 3'h5;
    function is_digit;
        input [7:0] c;
        begin
            is_digit = (c >= 8'h30 && c <= 8'h39);
        end
    endfunction
    function is_alpha;
        input [7:0] c;
        begin
            is_alpha = (c >= 8'h41 && c <= 8'h5A);
        end
    endfunction
    // classify one parameter byte, updating the running kind
    function [2:0] kind_step;
        input [2:0] k;
        input [7:0] c;
        begin
            kind_step = PK_BAD;
            if (k == PK_NONE)
                kind_step = is_alpha(c) ? PK_WORD :
                    (is_digit(c) || c == `CH_PLUS || c == `CH_MINUS) ?
                    PK_INT : (c == `CH_DOT) ? PK_REAL : PK_BAD;
            else if (k == PK_WORD)
                kind_step = is_alpha(c) || is_digit(c) ? PK_WORD : PK_BAD;
            else if (k == PK_INT || k == PK_REAL)
            begin
                if (is_digit(c))
                    kind_step = k;
                else if (c == `CH_DOT || c == `CH_E || c == `CH_PLUS ||
                         c == `CH_MINUS)
                    kind_step = PK_REAL;
                else if (c == `CH_K || c == `CH_M || c == `CH_G)
                    kind_step = PK_MULT;
            end
            else if (k == PK_MULT && is_alpha(c))
                kind_step = PK_MULT;                     // unit letters
        end
    endfunction
    reg [2:0] state_reg;
    reg [8:0] msg_cnt_reg;
    reg       head_any_reg, head_colon_reg, head_q_reg;
    reg       mav_reg, newmsg_reg, first_rmu_reg;
    reg [8:0] out_cnt_reg;
    wire      term = rx_stb & ((ch == `CH_LF) | eoi_s2);
    wire      sep  = (ch < `CH_SPACE || ch == `CH_SPACE) &&
                     ch != `CH_LF;
    wire      known = head_colon_reg ? 1'b1 : path_valid;
    // finish a command: flag command and execution errors in priority, else execute, flagging a device error if the setting is approximated
    task finish_cmd;
        begin
            if (!known)
            begin
                err_class <= `ERR_CMD;
                err_pulse <= 1'b1;
            end
            else if (param_kind == PK_BAD)
            begin
                err_class <= `ERR_CMD;
                err_pulse <= 1'b1;
            end
            else if (!mode_allows && !cmd_common)
            begin
                err_class <= `ERR_EXE;
                err_pulse <= 1'b1;
            end
            else
            begin
                cmd_exec <= 1'b1;
                if (setting_approx)
                begin
                    err_class <= `ERR_DEV;
                    err_pulse <= 1'b1;
                end
            end
        end
    endtask
    // command parser
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg      <= ST_HEAD;
            tree_level     <= `LVL_ROOT;
            msg_cnt_reg    <= 9'h000;
            head_any_reg   <= 1'b0;
            head_colon_reg <= 1'b0;
            head_q_reg     <= 1'b0;
            cmd_exec       <= 1'b0;
            cmd_common     <= 1'b0;
            cmd_query      <= 1'b0;
            cmd_first      <= 8'h00;
            param_kind     <= PK_NONE;
            err_class      <= `ERR_NONE;
            err_pulse      <= 1'b0;
            newmsg_reg     <= 1'b0;
        end
        else
        begin
            cmd_exec  <= 1'b0;
            err_pulse <= 1'b0;
            if (err_pulse)
                newmsg_reg <= 1'b1;
            if (rx_stb)
            begin
                if (msg_cnt_reg != `MSG_MAX_BYTES)
                    msg_cnt_reg <= msg_cnt_reg + 9'h001;
                if (term || ch == `CH_SEMI)
                begin
                    if (head_any_reg)
                        finish_cmd;
                    head_any_reg   <= 1'b0;
                    head_colon_reg <= 1'b0;
                    head_q_reg     <= 1'b0;
                    state_reg      <= ST_HEAD;
                    if (term)
                    begin
                        tree_level  <= `LVL_ROOT;
                        msg_cnt_reg <= 9'h000;
                    end
                end
                else
                begin
                    case (state_reg)
                    ST_HEAD:
                    begin
                        if (ch == `CH_COLON)
                        begin
                            if (!head_any_reg)
                                tree_level <= `LVL_ROOT;
                            else if (path_valid &&
                                     tree_level != `LVL_MAX)
                                tree_level <= tree_level + 2'h1;
                            head_colon_reg <= head_any_reg;
                        end
                        else if (!head_any_reg && ch == `CH_STAR)
                        begin
                            cmd_common   <= 1'b1;
                            cmd_first    <= ch;
                            param_kind   <= PK_NONE;
                            head_any_reg <= 1'b1;
                        end
                        else if (ch == `CH_QUERY)
                            head_q_reg <= 1'b1;
                        else if (sep)
                        begin
                            if (head_any_reg)
                                state_reg <= ST_GAP;
                        end
                        else
                        begin
                            if (!head_any_reg)
                            begin
                                cmd_first  <= ch;
                                cmd_common <= 1'b0;
                                param_kind <= PK_NONE;
                            end
                            head_any_reg <= 1'b1;
                        end
                        cmd_query <= head_q_reg | (ch == `CH_QUERY);
                    end
                    ST_GAP:
                        if (!sep)
                        begin
                            param_kind <= kind_step(PK_NONE, ch);
                            state_reg  <= ST_PARAM;
                        end
                    ST_PARAM:
                        if (ch == `CH_COMMA)
                        begin
                            if (param_kind == PK_NONE)
                                param_kind <= PK_BAD;
                            state_reg <= ST_GAP;
                        end
                        else if (!sep)
                            param_kind <= kind_step(param_kind, ch);
                    default:
                        state_reg <= ST_HEAD;
                    endcase
                end
            end
            else if (cmd_exec)
                cmd_common <= 1'b0;
        end
    end
    // response formatter: semicolons between units, commas in items
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            tx_data       <= 8'h00;
            tx_valid      <= 1'b0;
            tx_eoi        <= 1'b0;
            out_cnt_reg   <= 9'h000;
            first_rmu_reg <= 1'b1;
            mav_reg       <= 1'b0;
        end
        else
        begin
            if (tx_valid && tx_ready)
                tx_valid <= 1'b0;
            if (tx_valid && tx_ready && tx_eoi)
            begin
                tx_eoi        <= 1'b0;
                mav_reg       <= 1'b0;
                out_cnt_reg   <= 9'h000;
                first_rmu_reg <= 1'b1;
            end
            else if (cmd_exec && cmd_query && !first_rmu_reg &&
                     !tx_valid && out_cnt_reg != `RSP_MAX_CHARS)
            begin
                tx_data     <= `CH_SEMI;
                tx_valid    <= 1'b1;
                out_cnt_reg <= out_cnt_reg + 9'h001;
            end
            else if (rsp_valid && !tx_valid)
            begin
                mav_reg       <= 1'b1;
                first_rmu_reg <= 1'b0;
                if (out_cnt_reg != `RSP_MAX_CHARS)
                begin
                    tx_data     <= rsp_item_end ? `CH_COMMA :
                                   ((rsp_data >= 8'h61 &&
                                     rsp_data <= 8'h7A) ?
                                    (rsp_data & 8'hDF) : rsp_data);
                    tx_valid    <= 1'b1;
                    out_cnt_reg <= out_cnt_reg + 9'h001;
                end
            end
            else if (term && mav_reg && !tx_valid)
            begin
                tx_data  <= `CH_LF;
                tx_eoi   <= 1'b1;
                tx_valid <= 1'b1;
            end
        end
    end
    // status byte readable by query or poll
    status_byte_unit u_status
    (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .oper_busy     (oper_busy),
        .event_summary (event_summary),
        .msg_avail     (mav_reg),
        .new_status    (newmsg_reg),
        .sre_mask      (sre_mask),
        .poll_ack      (poll_ack),
        .status_reg    (service_status_byte),
        .srq_reg       (srq)
    );
endmodule

// >>> verification/scpi_parser_monitor.sv
`timescale 1ns/10ps
`include "msg_parser_defs.vh"
// watches parser and status outputs at the top ports
module scpi_parser_monitor
(
    input wire       ref_clk,
    input wire       reset,
    input wire [7:0] rx_data,
    input wire       rx_valid,
    input wire       oper_busy,
    input wire [7:0] sre_mask,
    input wire       tx_ready,
    input wire [7:0] tx_data,
    input wire       tx_valid,
    input wire       tx_eoi,
    input wire [1:0] tree_level,
    input wire       cmd_exec,
    input wire       cmd_common,
    input wire [7:0] cmd_first,
    input wire [1:0] err_class,
    input wire       err_pulse,
    input wire [7:0] service_status_byte,
    input wire       srq
);
    wire [7:0] sb;

    // short alias keeps the properties readable
    assign sb = service_status_byte;

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    zero_bits_a: assert property ((sb & 8'h0B) == 8'h00)
        else $error("status bits 3 1 0 not zero");
    busy_bit_a: assert property (
        $stable(oper_busy) [*4] |-> sb[`SB_OPER] == oper_busy)
        else $error("busy bit does not follow its input");
    mss_bit_a: assert property (
        ($stable(sre_mask) && $stable(sb)) [*3]
        |-> sb[`SB_MSS] == |(sb & sre_mask & 8'hBF))
        else $error("summary bit disagrees with masked byte");
    srq_drop_a: assert property ((!sb[`SB_MSS]) [*2] |-> !srq)
        else $error("service request without summary bit");
    root_reset_a: assert property (
        $fell(reset) |-> tree_level == `LVL_ROOT)
        else $error("tree position not root after reset");
    root_term_a: assert property (
        $rose(rx_valid) && rx_data == `CH_LF
        |-> ##[1:10] tree_level == `LVL_ROOT)
        else $error("terminator did not return tree to root");
    err_class_a: assert property (
        err_pulse |-> err_class != `ERR_NONE)
        else $error("error strobe with no class");
    tx_hold_a: assert property (
        tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_data) && $stable(tx_eoi))
        else $error("response byte changed while stalled");
    eoi_lf_a: assert property (
        tx_valid && tx_eoi |-> tx_data == `CH_LF)
        else $error("end marker on a byte other than line feed");
    upper_a: assert property (
        tx_valid |-> !(tx_data inside {[8'h61:8'h7A]}))
        else $error("lower case letter in response");
    star_a: assert property (
        cmd_exec && cmd_common |-> cmd_first == `CH_STAR)
        else $error("common command without asterisk");

    cover property (cmd_exec && cmd_common);
    cover property (err_pulse);
    cover property (srq);
endmodule

bind scpi_message_parser_status scpi_parser_monitor scpi_parser_monitor_inst
(
    .ref_clk, .reset, .rx_data, .rx_valid, .oper_busy, .sre_mask,
    .tx_ready, .tx_data, .tx_valid, .tx_eoi, .tree_level, .cmd_exec,
    .cmd_common, .cmd_first, .err_class, .err_pulse,
    .service_status_byte, .srq
);

// >>> verification/gpib_ctrl_model.sv
`timescale 1ns/10ps
// bus controller: sends program bytes, takes response bytes
module gpib_ctrl_model
(
    input  wire       ref_clk,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    input  wire       tx_eoi,
    input  wire       slow,
    output reg        tx_ready,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        rx_eoi
);
    reg [8:0] got[$];
    reg       ph;

    initial
    begin
        rx_data = 8'hA5;
        rx_valid = 1'b0;
        rx_eoi = 1'b0;
        tx_ready = 1'b0;
        ph = 1'b0;
    end

    // one byte per valid rise, held past the synchroniser
    task send_byte(input [7:0] b, input e);
        begin
            @(negedge ref_clk);
            rx_data = b;
            rx_eoi = e;
            rx_valid = 1'b1;
            repeat (4) @(negedge ref_clk);
            rx_valid = 1'b0;
            repeat (3) @(negedge ref_clk);
            rx_data = ~b;
            rx_eoi = 1'b0;
        end
    endtask

    // whole message, end marker on the last byte if asked
    task send_msg(input string s, input e);
        integer i;
        begin
            for (i = 0; i < s.len(); i = i + 1)
                send_byte(s[i], e && (i == s.len() - 1));
        end
    endtask

    // accept every cycle, or every other one when slow
    always @(negedge ref_clk)
    begin
        ph <= ~ph;
        tx_ready <= ~slow | ph;
    end

    // log accepted response bytes with their end marker
    always @(posedge ref_clk)
    begin
        if (tx_valid && tx_ready)
            got.push_back({tx_eoi, tx_data});
    end
endmodule

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
    typedef struct {string m; bit [2:0] c; bit [7:0] f; bit q;
                    bit [2:0] k; bit [1:0] e;} row_t;
    reg        ref_clk, reset, oper_busy, event_summary, path_valid;
    reg        mode_allows, setting_approx, poll_ack, rsp_valid;
    reg        rsp_item_end, slow;
    reg  [7:0] sre_mask, rsp_data;
    wire [7:0] rx_data, tx_data, cmd_first, service_status_byte;
    wire       rx_valid, rx_eoi, tx_ready, tx_valid, tx_eoi, cmd_exec;
    wire       cmd_common, cmd_query, err_pulse, srq;
    wire [1:0] tree_level, err_class;
    wire [2:0] param_kind;
    reg  [1:0] err_seen;
    reg [12:0] ex[$];
    integer    errors, cmp_count, i;
    string     s;
    row_t      rows[10];

    scpi_message_parser_status scpi_message_parser_status_inst
    (
        .ref_clk, .reset, .rx_data, .rx_valid, .rx_eoi, .oper_busy,
        .event_summary, .path_valid, .mode_allows, .setting_approx,
        .sre_mask, .poll_ack, .rsp_data, .rsp_valid, .rsp_item_end,
        .tx_ready, .tx_data, .tx_valid, .tx_eoi, .tree_level, .cmd_exec,
        .cmd_common, .cmd_query, .cmd_first, .param_kind, .err_class,
        .err_pulse, .service_status_byte, .srq
    );

    gpib_ctrl_model gpib_ctrl_model_inst
    (
        .ref_clk, .tx_data, .tx_valid, .tx_eoi, .slow, .tx_ready,
        .rx_data, .rx_valid, .rx_eoi
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // record command strobes and error classes
    always @(posedge ref_clk)
    begin
        if (cmd_exec)
            ex.push_back({cmd_query, cmd_common, param_kind, cmd_first});
        if (err_pulse)
            err_seen <= err_class;
    end

    task check(input string n, input [23:0] e, input [23:0] v);
        begin
            cmp_count = cmp_count + 1;
            if (v !== e)
            begin
                errors = errors + 1;
                $display("[FAIL] %s expected %h seen %h", n, e, v);
            end
        end
    endtask

    task wrap_up;
        begin
            if (errors == 0 && cmp_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // clear logs, send one message, let it settle
    task run(input string m, input e);
        begin
            @(negedge ref_clk);
            ex.delete();
            err_seen = 2'h0;
            gpib_ctrl_model_inst.send_msg(m, e);
            repeat (15) @(negedge ref_clk);
        end
    endtask

    // stop a hung run
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        errors = errors + 1;
        wrap_up;
    end

    initial
    begin
        {reset, oper_busy, event_summary, poll_ack, rsp_valid} = 5'h1F;
        {oper_busy, event_summary, poll_ack, rsp_valid} = 4'h0;
        {rsp_item_end, slow, sre_mask, rsp_data} = 18'h0;
        {path_valid, mode_allows, setting_approx} = 3'h6;
        {errors, cmp_count, err_seen} = 0;
        rows = '{'{":A 1\n", 3'h6, "A", 0, 2, 0},
                 '{"f\t1.5E3\n", 3'h6, "F", 0, 3, 0},
                 '{"b 2k\n", 3'h6, "B", 0, 4, 0},
                 '{"c on\n", 3'h6, "C", 0, 1, 0},
                 '{"*cls\n", 3'h6, "*", 0, 0, 0},
                 '{"*stb?\n", 3'h6, "*", 1, 0, 0},
                 '{"d 1x\n", 3'h6, "D", 0, 5, 1},
                 '{"e 1\n", 3'h4, "E", 0, 2, 2},
                 '{"g 1\n", 3'h7, "G", 0, 2, 3},
                 '{"zz 1\n", 3'h2, "Z", 0, 2, 1}};
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        check("reset", 0, {tree_level, srq, tx_valid, service_status_byte});
        foreach (rows[j])
        begin
            {path_valid, mode_allows, setting_approx} = rows[j].c;
            run(rows[j].m, 1'b0);
            check("error class", rows[j].e, err_seen);
            check("level", 0, tree_level);
            if (rows[j].e == 2'h0)
            begin
                check("exec count", 1, ex.size());
                check("command", {rows[j].q, rows[j].f == "*",
                      rows[j].k, rows[j].f}, ex[0]);
            end
        end
        {path_valid, mode_allows, setting_approx} = 3'h6;
        run(":P:Q 1,2;", 1'b0);
        check("level kept", 1, tree_level);
        run("R 3", 1'b1);
        check("level on end", 0, tree_level);
        check("exec on end", 1, ex.size());
        run("a 1;b 2\n", 1'b0);
        check("order", {"A", "B"}, {ex[0][7:0], ex[1][7:0]});
        s = "h";
        for (i = 0; i < 253; i = i + 1)
            s = {s, " "};
        run({s, "1\n"}, 1'b0);
        check("long", {13'h0248, 2'h0}, {ex[0], err_seen});
        // reset in mid-run from a lower tree level
        run(":P:Q 1;", 1'b0);
        check("level before reset", 1, tree_level);
        reset = 1'b1;
        @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        check("level after reset", 0, tree_level);
        // response with a stalling controller
        slow = 1'b1;
        gpib_ctrl_model_inst.got.delete();
        s = "a,b";
        for (i = 0; i < 3; i = i + 1)
        begin
            @(negedge ref_clk);
            rsp_data = s[i];
            rsp_item_end = (s[i] == ",");
            rsp_valid = 1'b1;
            @(negedge ref_clk);
            {rsp_valid, rsp_item_end} = 2'h0;
            repeat (3) @(negedge ref_clk);
        end
        repeat (30) @(negedge ref_clk);
        run("x\n", 1'b0);
        check("response end", 9'h10A, gpib_ctrl_model_inst.got[3]);
        check("response", "A,B", {gpib_ctrl_model_inst.got[0][7:0],
              gpib_ctrl_model_inst.got[1][7:0],
              gpib_ctrl_model_inst.got[2][7:0]});
        // status byte and service request
        {oper_busy, event_summary, sre_mask} = 10'h320;
        repeat (6) @(negedge ref_clk);
        check("status", 8'hE0, service_status_byte & 8'hEB);
        check("srq", 1, srq);
        poll_ack = 1'b1;
        @(negedge ref_clk);
        poll_ack = 1'b0;
        repeat (3) @(negedge ref_clk);
        check("srq after poll", 0, srq);
        {oper_busy, event_summary, sre_mask} = 10'h0;
        repeat (6) @(negedge ref_clk);
        check("status idle", 0, service_status_byte & 8'hEB);
        wrap_up;
    end
endmodule
